// [pkg/cbr_params.svh]
// Contract
// - Register at group base plus 0x20, read/write byte, resets to 0x02.
// - Bit 5 set selects back-to-back configuration, clear selects normal.
// - Bit 2 set freezes filter updates while cancelling continues.
// - Bit 4 set inserts fixed 12 dB receive path attenuation.
`ifndef CBR_PARAMS_SVH
`define CBR_PARAMS_SVH
`define CBR_GROUP_BASE 12'h000
`define CBR_CTRL_ONE_OFS 12'h020
`define CBR_CTRL_ONE_RESET 8'h02
`define CBR_BIT_INIT 7
`define CBR_BIT_NOISE_OFF 6
`define CBR_BIT_B2B 5
`define CBR_BIT_RX_ATTEN 4
`define CBR_BIT_BYPASS 3
`define CBR_BIT_FREEZE 2
`define CBR_BIT_RSV_ONE 1
`define CBR_BIT_RSV_ZERO 0
`define CBR_WRITABLE_MASK 8'h7c
`define CBR_RX_ATTEN_DB 12
`define CBR_INIT_CYCLES 4'h8
`endif

// [pkg/cbr_pkg.sv]
`default_nettype none
package cbr_pkg;
  typedef enum logic [1:0] {
    CBR_IDLE = 2'b01,
    CBR_INIT = 2'b10
  } cbr_state_t;
endpackage : cbr_pkg
`default_nettype wire

// [src/cbr_init_seq.sv]
`include "cbr_params.svh"
`default_nettype none
// Sequences an initialisation: a fixed-length pulse clearing coefficients
module cbr_init_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy
);
  cbr_pkg::cbr_state_t state;
  logic [3:0] count;

  // Coefficient clear lasts a few cycles so the datapath sees a firm level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= cbr_pkg::CBR_IDLE;
      count <= 4'h0;
    end
    else
    begin
      case (state)
        cbr_pkg::CBR_IDLE:
        begin
          if (start)
          begin
            state <= cbr_pkg::CBR_INIT;
            count <= `CBR_INIT_CYCLES - 4'h1;
          end
        end
        cbr_pkg::CBR_INIT:
        begin
          if (count == 4'h0)
            state <= cbr_pkg::CBR_IDLE;
          else
            count <= count - 4'h1;
        end
        default:
          state <= cbr_pkg::CBR_IDLE;
      endcase
    end
  end

  assign busy = (state == cbr_pkg::CBR_INIT);
endmodule : cbr_init_seq
`default_nettype wire

// [src/cbr_ctrl_one.sv]
`include "cbr_params.svh"
`default_nettype none
// Control register one of canceller B, APB slave with field outputs
module cbr_ctrl_one (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic back_to_back_sel,
  output logic rx_atten_on,
  output logic adapt_freeze,
  output logic noise_inject_off,
  output logic bypass_on,
  output logic coeff_clear
);
  logic [7:0] ctrl;
  logic hit;
  logic wr_fire;
  logic rd_fire;
  logic init_req;
  logic init_busy;

  assign hit = (paddr == (`CBR_GROUP_BASE + `CBR_CTRL_ONE_OFS));
  // Write lands at the edge where the master sees pready high, never earlier
  assign wr_fire = psel && penable && pwrite && pready;
  assign rd_fire = psel && penable && !pwrite && !pready;
  // Init requested only by a full byte write with bit 7 set
  assign init_req = wr_fire && hit && pstrb[0] && pwdata[`CBR_BIT_INIT];

  // One wait state: answer comes the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd_fire)
        prdata <= hit ? {24'h0, ctrl} : 32'h0;
      else
        prdata <= 32'h0;
    end
  end

  // Register store; reserved bits are fixed and init forces the reset value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `CBR_CTRL_ONE_RESET;
    else if (init_req)
      ctrl <= `CBR_CTRL_ONE_RESET;
    else if (wr_fire && hit && pstrb[0])
      ctrl <= (pwdata[7:0] & `CBR_WRITABLE_MASK) | `CBR_CTRL_ONE_RESET;
  end

  cbr_init_seq u_init (
    .pclk(pclk),
    .presetn(presetn),
    .start(init_req),
    .busy(init_busy)
  );

  // Field outputs registered; bit 7 reads back zero since the writable mask never stores it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      back_to_back_sel <= 1'b0;
      rx_atten_on <= 1'b0;
      adapt_freeze <= 1'b0;
      noise_inject_off <= 1'b0;
      bypass_on <= 1'b0;
      coeff_clear <= 1'b0;
    end
    else
    begin
      back_to_back_sel <= ctrl[`CBR_BIT_B2B];
      rx_atten_on <= ctrl[`CBR_BIT_RX_ATTEN];
      adapt_freeze <= ctrl[`CBR_BIT_FREEZE];
      noise_inject_off <= ctrl[`CBR_BIT_NOISE_OFF];
      bypass_on <= ctrl[`CBR_BIT_BYPASS];
      coeff_clear <= init_busy || init_req;
    end
  end

  property p_reset_value;
    @(posedge pclk) disable iff (!presetn) init_req |=> (ctrl == 8'h02);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("init did not restore 0x02");

  property p_rsv_bits;
    @(posedge pclk) disable iff (!presetn) ctrl[1:0] == 2'b10 && !ctrl[7];
  endproperty
  a_rsv_bits: assert property (p_rsv_bits) else $error("reserved bits wrong");

  property p_b2b;
    @(posedge pclk) disable iff (!presetn) ##1 back_to_back_sel == $past(ctrl[5]);
  endproperty
  a_b2b: assert property (p_b2b) else $error("back to back output mismatch");

  property p_freeze;
    @(posedge pclk) disable iff (!presetn) ##1 adapt_freeze == $past(ctrl[2]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze output mismatch");

  property p_atten;
    @(posedge pclk) disable iff (!presetn) ##1 rx_atten_on == $past(ctrl[4]);
  endproperty
  a_atten: assert property (p_atten) else $error("attenuation output mismatch");

  property p_clear_pulse;
    @(posedge pclk) disable iff (!presetn) init_req |=> coeff_clear [*8] ##1 coeff_clear ##1 !coeff_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("coefficient clear length wrong");

  property p_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && hit && pstrb[0] && !pwdata[7]) |=> (ctrl[6:2] == $past(pwdata[6:2]));
  endproperty
  a_write: assert property (p_write) else $error("write not stored");

  property p_ready;
    @(posedge pclk) disable iff (!presetn) (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready timing wrong");

  c_init: cover property (@(posedge pclk) disable iff (!presetn) init_req);
  c_b2b: cover property (@(posedge pclk) disable iff (!presetn) back_to_back_sel);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
endmodule : cbr_ctrl_one
`default_nettype wire

// [testbench/tb_cbr_ctrl_one.sv]
`default_nettype none
module tb_cbr_ctrl_one;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic back_to_back_sel, rx_atten_on, adapt_freeze, noise_inject_off, bypass_on, coeff_clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int miscompares = 0;
  int comparisons = 0;
  // Case equality so an unknown output never counts as a match
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, g); miscompares++; end end
  cbr_ctrl_one dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .back_to_back_sel(back_to_back_sel), .rx_atten_on(rx_atten_on), .adapt_freeze(adapt_freeze),
    .noise_inject_off(noise_inject_off), .bypass_on(bypass_on), .coeff_clear(coeff_clear));
  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // One APB transfer; the request is held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    `CHK("pready", 1'b1, pready)
  endtask : apb
  task t_reset;
    apb(0, 12'h020, 32'h0, 4'h0);
    `CHK("reset value", 32'h02, rd)
    `CHK("fields", 5'h00, {back_to_back_sel, rx_atten_on, adapt_freeze, noise_inject_off, bypass_on})
  endtask : t_reset
  task t_fields;
    // Canceller A is assumed programmed alike, extended delay off
    apb(1, 12'h020, 32'h36, 4'hf);
    repeat (2) @(negedge pclk);
    `CHK("back_to_back_sel", 1'b1, back_to_back_sel)
    `CHK("rx_atten_on", 1'b1, rx_atten_on)
    `CHK("adapt_freeze", 1'b1, adapt_freeze)
    apb(0, 12'h020, 32'h0, 4'h0);
    `CHK("readback", 32'h36, rd)
    apb(1, 12'h020, 32'h4a, 4'h1);
    repeat (2) @(negedge pclk);
    `CHK("normal config", 1'b0, back_to_back_sel)
    `CHK("adapting", 1'b0, adapt_freeze)
    `CHK("no attenuation", 1'b0, rx_atten_on)
    `CHK("other fields", 2'b11, {noise_inject_off, bypass_on})
  endtask : t_fields
  task t_refuse;
    // Strobe off and a wrong address must both leave the register alone
    apb(1, 12'h020, 32'h36, 4'he);
    apb(1, 12'h024, 32'h36, 4'hf);
    `CHK("unmapped err", 1'b1, err)
    apb(0, 12'h024, 32'h0, 4'h0);
    `CHK("unmapped read", 32'h0, rd)
    apb(0, 12'h020, 32'h0, 4'h0);
    `CHK("unchanged", 32'h4a, rd)
    `CHK("mapped err", 1'b0, err)
  endtask : t_refuse
  task t_init;
    apb(1, 12'h020, 32'hb6, 4'h1);
    repeat (2) @(negedge pclk);
    `CHK("coeff_clear on", 1'b1, coeff_clear)
    `CHK("fields cleared", 3'b000, {back_to_back_sel, adapt_freeze, noise_inject_off})
    apb(0, 12'h020, 32'h0, 4'h0);
    `CHK("after init", 32'h02, rd)
    repeat (12) @(negedge pclk);
    `CHK("coeff_clear off", 1'b0, coeff_clear)
  endtask : t_init
  task report_and_stop;
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // Whole run is about sixty cycles; this allows ample margin
  initial
  begin
    #20000;
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_fields;
    t_refuse;
    t_init;
    report_and_stop;
  end
endmodule : tb_cbr_ctrl_one
`default_nettype wire
